//--- src/cfgma_pkg.sv
// constants and types shared by both ends of the configuration message link
// Operation
// [RULE_01] write: token 192, id24, reg16, data32, end
// [RULE_02] read: token 193, id24, reg16, end token
// [RULE_03] write reply: 3,1 on success, 4,1 otherwise
// [RULE_04] read reply: 3, data word, 1; or 4,1
// [RULE_05] write id low byte all ones: no reply
// [RULE_06] multi-byte fields go most significant byte first
// [RULE_07] requester puts its upper 24 id bits
// [RULE_08] tile destination: tile id then low c20c
// [RULE_09] node destination: node id then low c30c
// [RULE_10] peripheral destination: node, peripheral, then 02
// [RULE_11] peripheral read: 37, id24, reg8, size8, end
// [RULE_12] peripheral read reply: 3, bytes, 1; or 4,1
// [RULE_13] status resource id: register shifted eight, or 0c
// [RULE_14] status read and write move one word
// [RULE_15] unknown register or malformed message: reply 4,1
package cfgma_pkg;
   // control token values
   localparam logic [7:0] TOK_WRITE   = 8'hc0;
   localparam logic [7:0] TOK_READ    = 8'hc1;
   localparam logic [7:0] TOK_PREAD   = 8'h25;
   localparam logic [7:0] TOK_END     = 8'h01;
   localparam logic [7:0] TOK_ACK     = 8'h03;
   localparam logic [7:0] TOK_NAK     = 8'h04;
   // field byte counts after the opening token
   localparam logic [3:0] LEN_WRITE   = 4'h9;
   localparam logic [3:0] LEN_READ    = 4'h5;
   localparam logic [3:0] LEN_PREAD   = 4'h5;
   localparam logic [2:0] WORD_BYTES  = 3'h4;
   localparam logic [7:0] NO_REPLY_ID = 8'hff;
   // destination low patterns and status resource tag
   localparam logic [15:0] DEST_TILE  = 16'hc20c;
   localparam logic [15:0] DEST_NODE  = 16'hc30c;
   localparam logic [7:0]  DEST_PERIPH = 8'h02;
   localparam logic [7:0]  PS_TAG     = 8'h0c;
   // implemented register space
   localparam int          CFG_REGS   = 8;
   localparam int          PS_REGS    = 8;
   localparam int          PER_BYTES  = 16;
   localparam logic [15:0] CFG_LIMIT  = 16'h0008;
   localparam logic [7:0]  PS_LIMIT   = 8'h08;
   localparam logic [8:0]  PER_LIMIT  = 9'h010;
   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

   typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_PREAD} cfgma_op_e;
   typedef enum logic [1:0] {TGT_TILE, TGT_NODE, TGT_PERIPH} cfgma_tgt_e;
   typedef enum logic [2:0] {E_IDLE, E_FIELD, E_END, E_DRAIN, E_REPLY} cfgma_ep_e;
   typedef enum logic [1:0] {R_IDLE, R_SEND, R_WAIT, R_DATA} cfgma_rq_e;
endpackage : cfgma_pkg

//--- src/cfgma_link_if.sv
// token link between requesting channel end and configuration endpoint
`timescale 1ns/10ps
interface cfgma_link_if;
   // request direction, requester to endpoint
   logic       reqValid;
   logic       reqCtrl;
   logic [7:0] reqByte;
   logic       reqReady;
   // reply direction, endpoint to requester
   logic       rspValid;
   logic       rspCtrl;
   logic [7:0] rspByte;
   logic       rspReady;

   modport endpoint (input reqValid, reqCtrl, reqByte, rspReady,
                     output reqReady, rspValid, rspCtrl, rspByte);
   modport requester (output reqValid, reqCtrl, reqByte, rspReady,
                      input reqReady, rspValid, rspCtrl, rspByte);
endinterface : cfgma_link_if

//--- src/cfgma_endpoint.sv
// configuration endpoint: parses request messages, keeps registers, replies
`timescale 1ns/10ps
module cfgma_endpoint (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     nrst,
   // message link
   cfgma_link_if.endpoint                link,
   // processor status word port
   input  wire logic                     psValid,
   input  wire logic                     psWrite,
   input  wire logic [31:0]              psResId,
   input  wire logic [31:0]              psWdata,
   output      logic                     psAck,
   output      logic                     psErr,
   output      logic [31:0]              psRdata,
   // register contents and peripheral bytes
   output      logic [cfgma_pkg::CFG_REGS-1:0][31:0] cfgRegs,
   input  wire logic [cfgma_pkg::PER_BYTES-1:0][7:0] periphBytes
);
   import cfgma_pkg::*;

   typedef struct packed {
      cfgma_ep_e                 state;
      cfgma_op_e                 op;
      logic [3:0]                cnt;
      logic [3:0]                need;
      logic [71:0]               fields;
      logic                      txValid;
      logic                      txCtrl;
      logic [7:0]                txByte;
      logic [2:0]                txLeft;
      logic [31:0]               txWord;
      logic                      txEnd;
      logic [CFG_REGS-1:0][31:0] cfg;
      logic [PS_REGS-1:0][31:0]  ps;
      logic                      psAck;
      logic                      psErr;
      logic [31:0]               psRdata;
   } cfgma_ep_s;

   cfgma_ep_s q, d;
   logic      reqTake;
   logic      rspTake;

   // refused only while replying
   assign link.reqReady = (q.state != E_REPLY);
   assign reqTake       = link.reqValid && link.reqReady;
   assign rspTake       = q.txValid && link.rspReady;
   assign link.rspValid = q.txValid;
   assign link.rspCtrl  = q.txCtrl;
   assign link.rspByte  = q.txByte;
   assign psAck         = q.psAck;
   assign psErr         = q.psErr;
   assign psRdata       = q.psRdata;
   assign cfgRegs       = q.cfg;

   // opens a reply; a failure carries no data
   function automatic cfgma_ep_s startReply(input cfgma_ep_s s, input logic ok,
                                            input logic [2:0] n, input logic [31:0] w);
      cfgma_ep_s r;
      r         = s;
      r.state   = E_REPLY;
      r.txValid = 1'b1;
      r.txCtrl  = 1'b1;
      r.txByte  = ok ? TOK_ACK : TOK_NAK;   // RULE_03
      r.txLeft  = ok ? n : 3'h0;
      r.txWord  = w;
      r.txEnd   = 1'b0;
      return r;
   endfunction : startReply

   // next state of the whole endpoint
   always_comb begin
      logic [23:0] rid;
      logic [15:0] rnum;
      logic [8:0]  span;
      logic [31:0] pword;
      logic [3:0]  idx;
      logic        ok;
      rid   = 24'h0;
      rnum  = 16'h0;
      span  = 9'h0;
      pword = 32'h0;
      idx   = 4'h0;
      ok    = 1'b0;
      d       = q;
      d.psAck = 1'b0;
      d.psErr = 1'b0;

      // status word access, one full word each way
      if (psValid) begin
         d.psAck = 1'b1;
         if (psResId[7:0] == PS_TAG && psResId[31:16] == 16'h0
             && psResId[15:8] < PS_LIMIT) begin
            if (psWrite) begin
               d.ps[psResId[10:8]] = psWdata;   // RULE_14
            end else begin
               d.psRdata = q.ps[psResId[10:8]];   // RULE_14
            end
         end else begin
            d.psErr = 1'b1;
         end
      end

      unique case (q.state)
         E_IDLE: begin
            if (reqTake) begin
               d.cnt = 4'h0;
               if (link.reqCtrl && link.reqByte == TOK_WRITE) begin
                  d.op    = OP_WRITE;   // RULE_01
                  d.need  = LEN_WRITE;
                  d.state = E_FIELD;
               end else if (link.reqCtrl && link.reqByte == TOK_READ) begin
                  d.op    = OP_READ;   // RULE_02
                  d.need  = LEN_READ;
                  d.state = E_FIELD;
               end else if (link.reqCtrl && link.reqByte == TOK_PREAD) begin
                  d.op    = OP_PREAD;   // RULE_11
                  d.need  = LEN_PREAD;
                  d.state = E_FIELD;
               end else if (link.reqCtrl && link.reqByte == TOK_END) begin
                  d = startReply(d, 1'b0, 3'h0, 32'h0);   // RULE_15
               end else begin
                  d.state = E_DRAIN;   // RULE_15
               end
            end
         end
         E_FIELD: begin
            if (reqTake) begin
               if (!link.reqCtrl) begin
                  // fields arrive most significant byte first
                  d.fields = {q.fields[63:0], link.reqByte};   // RULE_06
                  d.cnt    = q.cnt + 4'h1;
                  if (q.cnt + 4'h1 == q.need) begin
                     d.state = E_END;
                  end
               end else if (link.reqByte == TOK_END) begin
                  d = startReply(d, 1'b0, 3'h0, 32'h0);   // RULE_15
               end else begin
                  d.state = E_DRAIN;
               end
            end
         end
         E_END: begin
            if (reqTake && !(link.reqCtrl && link.reqByte == TOK_END)) begin
               d.state = E_DRAIN;   // RULE_15
            end else if (reqTake) begin
               unique case (q.op)
                  OP_WRITE: begin
                     rid  = q.fields[71:48];
                     rnum = q.fields[47:32];
                     ok   = rnum < CFG_LIMIT;
                     if (ok) begin
                        d.cfg[rnum[2:0]] = q.fields[31:0];   // RULE_01
                     end
                     if (rid[7:0] == NO_REPLY_ID) begin
                        d.state = E_IDLE;   // RULE_05
                     end else begin
                        d = startReply(d, ok, 3'h0, 32'h0);   // RULE_03
                     end
                  end
                  OP_READ: begin
                     rnum = q.fields[15:0];
                     ok   = rnum < CFG_LIMIT;
                     d    = startReply(d, ok, WORD_BYTES, q.cfg[rnum[2:0]]);   // RULE_04
                  end
                  default: begin
                     // peripheral read, one to four bytes, left aligned
                     span = {1'b0, q.fields[15:8]} + {1'b0, q.fields[7:0]};
                     ok   = q.fields[7:0] != 8'h0 && q.fields[7:0] <= {5'h0, WORD_BYTES}
                            && span <= PER_LIMIT;
                     for (int i = 0; i < 4; i++) begin
                        idx = q.fields[11:8] + 4'(i);
                        if (8'(i) < q.fields[7:0]) begin
                           pword[31-8*i -: 8] = periphBytes[idx];
                        end
                     end
                     d = startReply(d, ok, q.fields[2:0], pword);   // RULE_12
                  end
               endcase
            end
         end
         E_DRAIN: begin
            // malformed message swallowed to its end
            if (reqTake && link.reqCtrl && link.reqByte == TOK_END) begin
               d = startReply(d, 1'b0, 3'h0, 32'h0);   // RULE_15
            end
         end
         E_REPLY: begin
            if (rspTake) begin
               if (q.txEnd) begin
                  d.txValid = 1'b0;
                  d.state   = E_IDLE;
               end else if (q.txLeft != 3'h0) begin
                  d.txCtrl = 1'b0;
                  d.txByte = q.txWord[31:24];   // RULE_06
                  d.txWord = {q.txWord[23:0], 8'h00};
                  d.txLeft = q.txLeft - 3'h1;
               end else begin
                  d.txCtrl = 1'b1;
                  d.txByte = TOK_END;   // RULE_03
                  d.txEnd  = 1'b1;
               end
            end
         end
         default: begin
            d.state = E_IDLE;
         end
      endcase
   end

   // single state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q         <= '0;
         q.state   <= E_IDLE;
         q.op      <= OP_WRITE;
         q.cfg     <= {CFG_REGS{CFG_RESET}};
      end else begin
         q <= d;
      end
   end
endmodule : cfgma_endpoint

//--- src/cfgma_requester.sv
// requesting channel end: builds request messages and collects the reply
`timescale 1ns/10ps
module cfgma_requester (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   // message link
   cfgma_link_if.requester            link,
   // command port
   input  wire logic                  cmdValid,
   output      logic                  cmdReady,
   input  wire cfgma_pkg::cfgma_op_e  cmdOp,
   input  wire cfgma_pkg::cfgma_tgt_e cmdTarget,
   input  wire logic [31:0]           ownChanId,
   input  wire logic [15:0]           cmdNode,
   input  wire logic [7:0]            cmdPeriph,
   input  wire logic [15:0]           cmdReg,
   input  wire logic [31:0]           cmdData,
   input  wire logic [7:0]            cmdSize,
   // result
   output      logic                  done,
   output      logic                  doneOk,
   output      logic [31:0]           rdData,
   output      logic [31:0]           chanDest,
   output      logic [31:0]           psResId
);
   import cfgma_pkg::*;

   typedef struct packed {
      cfgma_rq_e   state;
      logic        txValid;
      logic        txCtrl;
      logic [7:0]  txByte;
      logic        txEnd;
      logic [71:0] fields;
      logic [3:0]  left;
      logic [2:0]  want;
      logic        noReply;
      logic        ok;
      logic [31:0] data;
      logic        done;
      logic [31:0] dest;
      logic [31:0] psRes;
   } cfgma_rq_s;

   cfgma_rq_s q, d;
   logic      cmdTake;
   logic      reqTake;
   logic      rspTake;

   // handshakes
   assign cmdReady      = (q.state == R_IDLE);
   assign cmdTake       = cmdValid && cmdReady;
   assign reqTake       = q.txValid && link.reqReady;
   assign link.reqValid = q.txValid;
   assign link.reqCtrl  = q.txCtrl;
   assign link.reqByte  = q.txByte;
   assign link.rspReady = (q.state == R_WAIT) || (q.state == R_DATA);
   assign rspTake       = link.rspValid && link.rspReady;
   assign done          = q.done;
   assign doneOk        = q.ok;
   assign rdData        = q.data;
   assign chanDest      = q.dest;
   assign psResId       = q.psRes;

   // next state of the whole requester
   always_comb begin
      logic [23:0] rid;
      rid    = ownChanId[31:8];   // RULE_07
      d      = q;
      d.done = 1'b0;
      unique case (q.state)
         R_IDLE: begin
            if (cmdTake) begin
               d.state   = R_SEND;
               d.txValid = 1'b1;
               d.txCtrl  = 1'b1;
               d.txEnd   = 1'b0;
               d.data    = 32'h0;
               d.noReply = 1'b0;
               d.psRes   = {8'h00, cmdReg, PS_TAG};   // RULE_13
               unique case (cmdTarget)
                  TGT_TILE:   d.dest = {cmdNode, DEST_TILE};   // RULE_08
                  TGT_NODE:   d.dest = {cmdNode, DEST_NODE};   // RULE_09
                  default:    d.dest = {cmdNode, cmdPeriph, DEST_PERIPH};   // RULE_10
               endcase
               unique case (cmdOp)
                  OP_WRITE: begin
                     d.txByte  = TOK_WRITE;   // RULE_01
                     d.fields  = {rid, cmdReg, cmdData};
                     d.left    = LEN_WRITE;
                     d.want    = 3'h0;
                     d.noReply = rid[7:0] == NO_REPLY_ID;   // RULE_05
                  end
                  OP_READ: begin
                     d.txByte = TOK_READ;   // RULE_02
                     d.fields = {rid, cmdReg, 32'h0};
                     d.left   = LEN_READ;
                     d.want   = WORD_BYTES;
                  end
                  default: begin
                     d.txByte = TOK_PREAD;   // RULE_11
                     d.fields = {rid, cmdReg[7:0], cmdSize, 32'h0};
                     d.left   = LEN_PREAD;
                     d.want   = cmdSize > 8'h4 ? WORD_BYTES : cmdSize[2:0];
                  end
               endcase
            end
         end
         R_SEND: begin
            if (reqTake) begin
               if (q.txEnd) begin
                  d.txValid = 1'b0;
                  if (q.noReply) begin
                     d.ok    = 1'b1;   // RULE_05
                     d.done  = 1'b1;
                     d.state = R_IDLE;
                  end else begin
                     d.state = R_WAIT;
                  end
               end else if (q.left != 4'h0) begin
                  d.txCtrl = 1'b0;
                  d.txByte = q.fields[71:64];   // RULE_06
                  d.fields = {q.fields[63:0], 8'h00};
                  d.left   = q.left - 4'h1;
               end else begin
                  d.txCtrl = 1'b1;
                  d.txByte = TOK_END;
                  d.txEnd  = 1'b1;
               end
            end
         end
         R_WAIT: begin
            // any opening but success is failure
            if (rspTake) begin
               d.state = R_DATA;
               d.ok    = link.rspCtrl && link.rspByte == TOK_ACK;
               if (!(link.rspCtrl && link.rspByte == TOK_ACK)) begin
                  d.want = 3'h0;
               end
            end
         end
         R_DATA: begin
            if (rspTake) begin
               if (!link.rspCtrl && q.want != 3'h0) begin
                  d.data = {q.data[23:0], link.rspByte};   // RULE_06
                  d.want = q.want - 3'h1;
               end else if (link.rspCtrl && link.rspByte == TOK_END) begin
                  d.ok    = q.ok && q.want == 3'h0;
                  d.done  = 1'b1;
                  d.state = R_IDLE;
               end else begin
                  d.ok = 1'b0;
               end
            end
         end
         default: begin
            d.state = R_IDLE;
         end
      endcase
   end

   // single state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q       <= '0;
         q.state <= R_IDLE;
      end else begin
         q <= d;
      end
   end
endmodule : cfgma_requester

//--- verif/cfgma_assertions.sv
// link checker: framing, lengths and reply shape of configuration messages
`timescale 1ns/10ps
module cfgma_assertions (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       nrst,
   // request direction
   input wire logic       reqValid,
   input wire logic       reqCtrl,
   input wire logic [7:0] reqByte,
   input wire logic       reqReady,
   // reply direction
   input wire logic       rspValid,
   input wire logic       rspCtrl,
   input wire logic [7:0] rspByte,
   input wire logic       rspReady
);
   import cfgma_pkg::*;
   logic       inMsg_q;
   logic [7:0] opTok_q;
   logic [3:0] cnt_q;
   logic [7:0] idLow_q;
   logic       reqTake;
   logic       rspTake;
   logic       endTake;
   logic       quiet;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // take strobes and the no-reply case
   assign reqTake = reqValid && reqReady;
   assign rspTake = rspValid && rspReady;
   assign endTake = reqTake && inMsg_q && reqCtrl && reqByte == TOK_END;
   assign quiet   = opTok_q == TOK_WRITE && idLow_q == NO_REPLY_ID && cnt_q == LEN_WRITE;

   // message tracker, opening token kept
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         inMsg_q <= 1'b0;
         opTok_q <= 8'h00;
         cnt_q   <= 4'h0;
         idLow_q <= 8'h00;
      end else if (reqTake && !inMsg_q) begin
         inMsg_q <= reqCtrl && reqByte != TOK_END;
         opTok_q <= reqByte;
         cnt_q   <= 4'h0;
      end else if (reqTake && reqCtrl) begin
         inMsg_q <= 1'b0;
      end else if (reqTake) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'h2) idLow_q <= reqByte; // third id byte is the low one
      end
   end

   property p_open_token;
      reqTake && !inMsg_q |-> reqCtrl
         && (reqByte == TOK_WRITE || reqByte == TOK_READ || reqByte == TOK_PREAD);
   endproperty
   a_open_token: assert property (p_open_token) else $error("bad opening token");

   property p_write_len;
      endTake && opTok_q == TOK_WRITE |-> cnt_q == LEN_WRITE;
   endproperty
   a_write_len: assert property (p_write_len) else $error("write length wrong");

   property p_read_len;
      endTake && opTok_q == TOK_READ |-> cnt_q == LEN_READ;
   endproperty
   a_read_len: assert property (p_read_len) else $error("read length wrong");

   property p_pread_len;
      endTake && opTok_q == TOK_PREAD |-> cnt_q == LEN_PREAD;
   endproperty
   a_pread_len: assert property (p_pread_len) else $error("periph length wrong");

   property p_reply_start;
      endTake && !quiet |=> rspValid && rspCtrl && (rspByte == TOK_ACK || rspByte == TOK_NAK);
   endproperty
   a_reply_start: assert property (p_reply_start) else $error("reply late or bad");

   property p_no_reply;
      endTake && quiet |=> !rspValid [*4];
   endproperty
   a_no_reply: assert property (p_no_reply) else $error("reply sent on ff id");

   property p_write_ack;
      rspTake && rspCtrl && rspByte == TOK_ACK && opTok_q == TOK_WRITE
         |=> rspValid && rspCtrl && rspByte == TOK_END;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("write ack not closed");

   property p_read_data;
      rspTake && rspCtrl && rspByte == TOK_ACK && opTok_q == TOK_READ
         |=> (rspValid && !rspCtrl) [*4] ##1 (rspValid && rspCtrl && rspByte == TOK_END);
   endproperty
   a_read_data: assert property (p_read_data) else $error("read reply shape");

   property p_nak_end;
      rspTake && rspCtrl && rspByte == TOK_NAK
         |=> rspValid && rspCtrl && rspByte == TOK_END ##1 !rspValid;
   endproperty
   a_nak_end: assert property (p_nak_end) else $error("failure reply shape");

   property p_quiet_reply;
      rspValid |-> !reqReady;
   endproperty
   a_quiet_reply: assert property (p_quiet_reply) else $error("ready during reply");
endmodule : cfgma_assertions

//--- verif/tb.sv
// self-checking bench joining requester and endpoint over one link
`timescale 1ns/10ps
module tb;
   import cfgma_pkg::*;
   // clock, reset and counters
   logic core_clk;
   logic nrst;
   int   errors;
   int   nTests;
   // requester command side
   logic        cmdValid;
   logic        cmdReady;
   cfgma_op_e   cmdOp;
   cfgma_tgt_e  cmdTarget;
   logic [31:0] ownChanId;
   logic [15:0] cmdNode;
   logic [7:0]  cmdPeriph;
   logic [15:0] cmdReg;
   logic [31:0] cmdData;
   logic [7:0]  cmdSize;
   logic        done;
   logic        doneOk;
   logic [31:0] rdData;
   logic [31:0] chanDest;
   logic [31:0] reqPsId;
   // endpoint status side and register views
   logic                      psValid;
   logic                      psWrite;
   logic [31:0]               psResId;
   logic [31:0]               psWdata;
   logic                      psAck;
   logic                      psErr;
   logic [31:0]               psRdata;
   logic [CFG_REGS-1:0][31:0] cfgRegs;
   logic [PER_BYTES-1:0][7:0] periphBytes;
   // taken tokens, {ctrl, byte}
   logic [8:0] reqQ[$];
   logic [8:0] rspQ[$];
   logic       okSeen;

   cfgma_link_if link ();
   cfgma_requester cfgma_requester_inst (.core_clk, .nrst, .link, .cmdValid, .cmdReady,
      .cmdOp, .cmdTarget, .ownChanId, .cmdNode, .cmdPeriph, .cmdReg, .cmdData, .cmdSize,
      .done, .doneOk, .rdData, .chanDest, .psResId(reqPsId));
   cfgma_endpoint cfgma_endpoint_inst (.core_clk, .nrst, .link, .psValid, .psWrite,
      .psResId, .psWdata, .psAck, .psErr, .psRdata, .cfgRegs, .periphBytes);
   cfgma_assertions cfgma_assertions_inst (.core_clk, .nrst,
      .reqValid(link.reqValid), .reqCtrl(link.reqCtrl), .reqByte(link.reqByte),
      .reqReady(link.reqReady), .rspValid(link.rspValid), .rspCtrl(link.rspCtrl),
      .rspByte(link.rspByte), .rspReady(link.rspReady));

   // 250 MHz clock
   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;

   // token log at mid-cycle
   always @(negedge core_clk) begin
      if (link.reqValid && link.reqReady) reqQ.push_back({link.reqCtrl, link.reqByte});
      if (link.rspValid && link.rspReady) rspQ.push_back({link.rspCtrl, link.rspByte});
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one command; returns just after done
   task automatic do_cmd(input cfgma_op_e op, input logic [15:0] rg, input logic [31:0] dt,
                         input logic [7:0] sz);
      int i;
      reqQ.delete();
      rspQ.delete();
      cmdOp    = op;
      cmdReg   = rg;
      cmdData  = dt;
      cmdSize  = sz;
      cmdValid = 1'b1;
      for (i = 0; i < 20 && cmdReady !== 1'b1; i++) begin
         @(posedge core_clk) #1;
      end
      @(posedge core_clk);
      #1 cmdValid = 1'b0;
      for (i = 0; i < 100; i++) begin
         if (done === 1'b1) break;
         @(posedge core_clk) #1;
      end
      check("done", done, 1'b1);
      okSeen = doneOk;
   endtask : do_cmd

   task automatic t_tile;
      logic [87:0] ex;
      cmdTarget = TGT_TILE;
      do_cmd(OP_WRITE, 16'h0003, 32'h1234_5678, 8'h00);
      ex = {TOK_WRITE, ownChanId[31:8], 16'h0003, 32'h1234_5678, TOK_END};
      check("req count", reqQ.size(), 11);
      for (int i = 0; i < 11; i++)
         check("req token", 32'(reqQ[i]), {i == 0 || i == 10, ex[87-8*i -: 8]});
      check("reply id", {reqQ[1][7:0], reqQ[2][7:0], reqQ[3][7:0]}, 24'h000301);
      check("tile dest", chanDest, {cmdNode, DEST_TILE});
      check("status id", reqPsId, {8'h00, 16'h0003, PS_TAG});
      check("write reg", cfgRegs[3], 32'h1234_5678);
      check("write rsp", {rspQ.size(), rspQ[0], rspQ[1]}, {14'h2, 9'h103, 9'h101});
      do_cmd(OP_READ, 16'h0003, 32'h0, 8'h00);
      check("read req", {reqQ.size(), reqQ[0], reqQ[6]}, {14'h7, 9'h1c1, 9'h101});
      check("read ok", okSeen, 1'b1);
      check("read data", rdData, 32'h1234_5678);
      check("read msb", {rspQ.size(), rspQ[1], rspQ[5]}, {14'h6, 9'h012, 9'h101});
      $display("test tile done");
   endtask : t_tile

   task automatic t_node;
      cmdTarget = TGT_NODE;
      do_cmd(OP_WRITE, 16'h0007, 32'hcafe_0007, 8'h00);
      check("node dest", chanDest, {cmdNode, DEST_NODE});
      do_cmd(OP_READ, 16'h0007, 32'h0, 8'h00);
      check("node read", rdData, 32'hcafe_0007);
      do_cmd(OP_READ, 16'h0008, 32'h0, 8'h00);
      check("bad read", {okSeen, rspQ[0], rspQ[1]}, {1'b0, 9'h104, 9'h101});
      do_cmd(OP_WRITE, 16'h0100, 32'h5555_aaaa, 8'h00);
      check("bad write", {okSeen, rspQ[0], rspQ[1]}, {1'b0, 9'h104, 9'h101});
      ownChanId = 32'h0003_ff00;
      do_cmd(OP_WRITE, 16'h0002, 32'h0bad_f00d, 8'h00);
      repeat (4) @(posedge core_clk);
      #1;
      check("no reply", rspQ.size(), 0);
      check("quiet write", cfgRegs[2], 32'h0bad_f00d);
      ownChanId = 32'h0003_0102;
      $display("test node done");
   endtask : t_node

   task automatic t_pread;
      logic [31:0] ex;
      cmdTarget = TGT_PERIPH;
      for (int s = 1; s <= 4; s++) begin
         do_cmd(OP_PREAD, 16'h000c, 32'h0, 8'(s));
         ex = 32'h0;
         for (int k = 0; k < s; k++) ex = {ex[23:0], 8'h1c + 8'(k)};
         check("pread req", {reqQ[4], reqQ[5]}, {9'h00c, 9'(s)});
         check("pread data", {okSeen, rdData}, {1'b1, ex});
      end
      check("periph dest", chanDest, {cmdNode, cmdPeriph, DEST_PERIPH});
      do_cmd(OP_PREAD, 16'h0000, 32'h0, 8'h05);
      check("pread size", {okSeen, rspQ[0]}, {1'b0, 9'h104});
      do_cmd(OP_PREAD, 16'h000d, 32'h0, 8'h04);
      check("pread range", {okSeen, rspQ[0], rspQ[1]}, {1'b0, 9'h104, 9'h101});
      $display("test periph done");
   endtask : t_pread

   // status access, request left up
   task automatic ps_op(input logic wr, input logic [7:0] rg, input logic [31:0] wd);
      psValid = 1'b1;
      psWrite = wr;
      psResId = {16'h0000, rg, PS_TAG};
      psWdata = wd;
      @(posedge core_clk) #1;
   endtask : ps_op

   task automatic t_ps;
      ps_op(1'b1, 8'h05, 32'hdead_beef);
      check("ps write", {psAck, psErr}, 2'b10);
      ps_op(1'b0, 8'h05, 32'h0);
      check("ps read", {psAck, psErr, psRdata}, {2'b10, 32'hdead_beef});
      ps_op(1'b0, 8'h08, 32'h0);
      check("ps bad id", {psAck, psErr}, 2'b11);
      ps_op(1'b0, 8'h07, 32'h0);
      check("ps last id", {psAck, psErr}, 2'b10);
      psValid = 1'b0;
      @(posedge core_clk) #1;
      check("ps idle", psAck, 1'b0);
      $display("test status done");
   endtask : t_ps

   task automatic summarize;
      $display("checks %0d mismatches %0d", nTests, errors);
      if (errors == 0 && nTests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // main sequence
   initial begin
      errors    = 0;
      nTests    = 0;
      nrst      = 1'b0;
      cmdValid  = 1'b0;
      cmdTarget = TGT_TILE;
      ownChanId = 32'h0003_0102;
      cmdNode   = 16'h0012;
      cmdPeriph = 8'h34;
      psValid   = 1'b0;
      for (int k = 0; k < PER_BYTES; k++) periphBytes[k] = 8'h10 + 8'(k);
      repeat (2) @(posedge core_clk);
      #1 nrst = 1'b1;
      t_tile();
      t_node();
      t_pread();
      t_ps();
      summarize();
   end

   // hang guard, tests need under 1000 cycles
   initial begin
      #(4 * 5000);
      errors++;
      $display("mismatch watchdog expected finish seen hang");
      summarize();
   end
endmodule : tb
